// [src/eecs_sequencer.sv]
// epp/ecp cycle sequencer between a request port and the 1284 pins
// assumes pin inputs are asynchronous; peripheral answers every strobe
`timescale 1ns/1ps
// What this block does
// - retry access when port cycle overruns budget
// - retried epp data access never restarts cycle
// - retried epp address access never restarts cycle
// - data cycle: afd high three clocks after busy
// - writes: close strobe two clocks after busy low
// - address write: slin high four after busy
// - reads: strobe low, busy answers, ends low
// - filters add two clocks to responses
// - fifo write completes, starts forward transfer
// - next fifo write retried until current transfer starts
// - forward: stb high two after busy, end two
// - reverse: afd low three after ack low
// - reverse: afd high two after ack high, stored unless full
// - fifo read never touches reverse transfer
module eecs_sequencer #(
    parameter int FIFO_DEPTH = 16
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // request port
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [1:0] req_target,
    input wire logic [7:0] req_wdata,
    output logic req_done,
    output logic req_retry,
    output logic [7:0] req_rdata,
    // mode controls
    input wire logic filter_en,
    input wire logic ecp_reverse,
    // parallel port pins
    input wire logic busy_pin,
    input wire logic ack_n_pin,
    input wire logic [7:0] pdata_in,
    output logic [7:0] pdata_out,
    output logic pdata_oe_n,
    output logic stb_n,
    output logic afd_n,
    output logic slin_n
);
    localparam int AW = $clog2(FIFO_DEPTH);
    if (FIFO_DEPTH < 2 || (1 << AW) != FIFO_DEPTH) begin : g_depth_check
        $error("FIFO_DEPTH must be a power of two, at least 2");
    end

    // input synchronisers
    logic [1:0] busy_sync, ack_sync;
    logic [7:0] pd_s1, pd_s2;
    logic busy_s, ack_n_s;
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            busy_sync <= 2'h0;
            ack_sync <= 2'h3;
            pd_s1 <= 8'h00;
            pd_s2 <= 8'h00;
        end else begin
            busy_sync <= {busy_sync[0], busy_pin};
            ack_sync <= {ack_sync[0], ack_n_pin};
            pd_s1 <= pdata_in;
            pd_s2 <= pd_s1;
        end
    end
    assign busy_s = busy_sync[1];
    assign ack_n_s = ack_sync[1];

    // reverse-mode data store
    logic [7:0] fifo_mem [FIFO_DEPTH];
    logic [AW:0] wr_ptr, rd_ptr;
    logic fifo_full, fifo_empty, fifo_push;
    assign fifo_full = (wr_ptr[AW] != rd_ptr[AW]) &&
        (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
    assign fifo_empty = (wr_ptr == rd_ptr);

    eecs_pkg::eecs_state_type state;
    logic [4:0] dly, budget;
    logic cyc_write, cyc_addr, cyc_ecp;
    logic pend_valid, pend_write, pend_addr;
    logic cyc_done, fwd_pend;
    logic [7:0] fwd_byte, held_byte;
    logic busy_acc, fifo_acc, epp_acc, same_acc;
    logic [4:0] extra;

    assign extra = filter_en ? 5'(eecs_pkg::DLY_FILTER_EXTRA) : 5'h00;
    assign epp_acc = req_valid && req_target != eecs_pkg::TGT_ECP_FIFO;
    assign fifo_acc = req_valid && req_target == eecs_pkg::TGT_ECP_FIFO;
    assign same_acc = pend_valid && pend_write == req_write &&
        pend_addr == (req_target == eecs_pkg::TGT_EPP_ADDR);
    assign busy_acc = state != eecs_pkg::ST_IDLE || cyc_done;

    // request answers: combinational handshake
    always_comb begin
        req_done = 1'b0;
        req_retry = 1'b0;
        if (fifo_acc) begin
            req_done = req_write ? !fwd_pend : 1'b1;
            req_retry = req_write && fwd_pend;
        end else if (epp_acc) begin
            if (same_acc && cyc_done)
                req_done = 1'b1;
            else if (budget == 5'(eecs_pkg::RETRY_BUDGET - 1))
                req_retry = 1'b1;
        end
    end

    // read data register
    always_ff @(posedge sys_clk) begin
        if (!rst_n)
            req_rdata <= eecs_pkg::PORT_DATA_RST;
        else if (fifo_acc && !req_write)
            req_rdata <= fifo_empty ? 8'h00 : fifo_mem[rd_ptr[AW-1:0]];
        else if (epp_acc && !req_write)
            req_rdata <= held_byte;
    end

    // pci-side clock budget per access attempt
    always_ff @(posedge sys_clk) begin
        if (!rst_n || !epp_acc || req_done || req_retry)
            budget <= eecs_pkg::CNT_RST;
        else
            budget <= budget + 5'h01;
    end

    // forward byte queue of one
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            fwd_pend <= 1'b0;
            fwd_byte <= eecs_pkg::PORT_DATA_RST;
        end else if (fifo_acc && req_write && !fwd_pend) begin
            fwd_pend <= 1'b1;
            fwd_byte <= req_wdata;
        end else if (state == eecs_pkg::ST_IDLE && !cyc_done && !ecp_reverse
                && !epp_acc) begin
            fwd_pend <= 1'b0;
        end
    end

    // reverse store pointers
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (fifo_push) begin
                fifo_mem[wr_ptr[AW-1:0]] <= pd_s2;
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (fifo_acc && !req_write && !fifo_empty)
                rd_ptr <= rd_ptr + 1'b1;
        end
    end

    // port cycle sequencer
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state <= eecs_pkg::ST_IDLE;
            dly <= eecs_pkg::CNT_RST;
            cyc_write <= 1'b0;
            cyc_addr <= 1'b0;
            cyc_ecp <= 1'b0;
            pend_valid <= 1'b0;
            pend_write <= 1'b0;
            pend_addr <= 1'b0;
            cyc_done <= 1'b0;
            held_byte <= eecs_pkg::PORT_DATA_RST;
            fifo_push <= 1'b0;
            stb_n <= 1'b1;
            afd_n <= 1'b1;
            slin_n <= 1'b1;
            pdata_out <= eecs_pkg::PORT_DATA_RST;
            pdata_oe_n <= 1'b1;
        end else begin
            fifo_push <= 1'b0;
            dly <= dly + 5'h01;
            if (req_done && epp_acc) begin
                cyc_done <= 1'b0;
                pend_valid <= 1'b0;
            end
            case (state)
            eecs_pkg::ST_IDLE: begin
                dly <= eecs_pkg::CNT_RST;
                if (epp_acc && !busy_acc) begin
                    pend_valid <= 1'b1;
                    pend_write <= req_write;
                    pend_addr <= req_target == eecs_pkg::TGT_EPP_ADDR;
                    cyc_write <= req_write;
                    cyc_addr <= req_target == eecs_pkg::TGT_EPP_ADDR;
                    cyc_ecp <= 1'b0;
                    pdata_out <= req_wdata;
                    pdata_oe_n <= !req_write;
                    if (req_target == eecs_pkg::TGT_EPP_ADDR)
                        slin_n <= 1'b0;
                    else
                        afd_n <= 1'b0;
                    state <= eecs_pkg::ST_WAIT_HI;
                end else if (ecp_reverse && !ack_n_s) begin
                    pdata_oe_n <= 1'b1;
                    state <= eecs_pkg::ST_REV_DLY_ACK;
                end else if (!ecp_reverse && fwd_pend && !cyc_done) begin
                    cyc_ecp <= 1'b1;
                    pdata_out <= fwd_byte;
                    pdata_oe_n <= 1'b0;
                    stb_n <= 1'b0;
                    state <= eecs_pkg::ST_WAIT_HI;
                end
            end
            eecs_pkg::ST_WAIT_HI: begin
                dly <= eecs_pkg::CNT_RST;
                if (busy_s)
                    state <= eecs_pkg::ST_DLY_RISE;
            end
            eecs_pkg::ST_DLY_RISE: begin
                if (cyc_ecp) begin
                    if (dly == 5'(eecs_pkg::DLY_ECP_FWD_RISE - 1)
                            + extra) begin
                        stb_n <= 1'b1;
                        state <= eecs_pkg::ST_WAIT_LO;
                    end
                end else if (cyc_addr) begin
                    if (dly == (cyc_write
                            ? 5'(eecs_pkg::DLY_EPP_ADDR_W_RISE - 1)
                            : 5'(eecs_pkg::DLY_EPP_ADDR_R_RISE - 1)) + extra)
                    begin
                        slin_n <= 1'b1;
                        state <= eecs_pkg::ST_WAIT_LO;
                    end
                end else if (dly == 5'(eecs_pkg::DLY_EPP_DATA_RISE - 1)
                        + extra) begin
                    afd_n <= 1'b1;
                    state <= eecs_pkg::ST_WAIT_LO;
                end
            end
            eecs_pkg::ST_WAIT_LO: begin
                dly <= eecs_pkg::CNT_RST;
                if (!busy_s) begin
                    if (!cyc_write && !cyc_ecp) begin
                        held_byte <= pd_s2;
                        cyc_done <= 1'b1;
                        state <= eecs_pkg::ST_IDLE;
                    end else begin
                        state <= eecs_pkg::ST_DLY_END;
                    end
                end
            end
            eecs_pkg::ST_DLY_END: begin
                if (dly == (cyc_ecp ? 5'(eecs_pkg::DLY_ECP_FWD_END - 1)
                        : 5'(eecs_pkg::DLY_EPP_END - 1)) + extra) begin
                    if (!cyc_ecp) begin
                        if (cyc_addr)
                            slin_n <= 1'b0;
                        else
                            stb_n <= 1'b0;
                        cyc_done <= 1'b1;
                    end
                    state <= eecs_pkg::ST_IDLE;
                end
            end
            eecs_pkg::ST_REV_DLY_ACK: begin
                if (dly == 5'(eecs_pkg::DLY_ECP_REV_ASSERT - 1) + extra) begin
                    afd_n <= 1'b0;
                    state <= eecs_pkg::ST_REV_WAIT_HI;
                end
            end
            eecs_pkg::ST_REV_WAIT_HI: begin
                dly <= eecs_pkg::CNT_RST;
                if (ack_n_s) begin
                    fifo_push <= !fifo_full;
                    state <= eecs_pkg::ST_REV_DLY_END;
                end
            end
            eecs_pkg::ST_REV_DLY_END: begin
                if (dly == 5'(eecs_pkg::DLY_ECP_REV_RELEASE - 1) + extra) begin
                    afd_n <= 1'b1;
                    state <= eecs_pkg::ST_IDLE;
                end
            end
            default: state <= eecs_pkg::ST_IDLE;
            endcase
            // write strobe returns high once the retry collects the cycle
            if (req_done && epp_acc && cyc_write) begin
                stb_n <= 1'b1;
                slin_n <= 1'b1;
            end
        end
    end
endmodule // eecs_sequencer

// [src/eecs_pkg.sv]
// constants shared by the epp/ecp cycle sequencer
// assumes a 50 MHz system clock with synchronous reset
package eecs_pkg;
    // access targets on the request port
    localparam logic [1:0] TGT_EPP_DATA = 2'h0;
    localparam logic [1:0] TGT_EPP_ADDR = 2'h1;
    localparam logic [1:0] TGT_ECP_FIFO = 2'h2;
    // clock budget before an access is retried
    localparam int RETRY_BUDGET = 16;
    // response delays from the sampling edge, filters off
    localparam int DLY_EPP_DATA_RISE = 3;
    localparam int DLY_EPP_ADDR_W_RISE = 4;
    localparam int DLY_EPP_ADDR_R_RISE = 3;
    localparam int DLY_EPP_END = 2;
    localparam int DLY_ECP_FWD_RISE = 2;
    localparam int DLY_ECP_FWD_END = 2;
    localparam int DLY_ECP_REV_ASSERT = 3;
    localparam int DLY_ECP_REV_RELEASE = 2;
    localparam int DLY_FILTER_EXTRA = 2;
    // reset values
    localparam logic [7:0] PORT_DATA_RST = 8'h00;
    localparam logic [4:0] CNT_RST = 5'h00;
    typedef enum logic [3:0] {
        ST_IDLE, ST_STROBE, ST_WAIT_HI, ST_DLY_RISE, ST_WAIT_LO,
        ST_DLY_END, ST_REV_DLY_ACK, ST_REV_WAIT_HI, ST_REV_DLY_END
    } eecs_state_type;
endpackage

// [tb/eecs_checker.sv]
// port assertions for the epp/ecp cycle sequencer
// assumes pins pass the same two-flop sampling as inside the design
`timescale 1ns/1ps
module eecs_checker (
    // clock and reset
    input wire logic sys_clk, input wire logic rst_n,
    // request port and modes
    input wire logic req_valid, input wire logic [1:0] req_target,
    input wire logic req_write, input wire logic req_done,
    input wire logic req_retry, input wire logic filter_en,
    input wire logic ecp_reverse,
    // pins
    input wire logic busy_pin, input wire logic ack_n_pin,
    input wire logic pdata_oe_n, input wire logic stb_n,
    input wire logic afd_n, input wire logic slin_n
);
    logic [1:0] bsy;
    logic [1:0] ack;
    logic [4:0] wait_cnt;
    logic fifo;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    assign fifo = req_target == eecs_pkg::TGT_ECP_FIFO;
    // pin sampling and attempt length
    always_ff @(posedge sys_clk) begin
        bsy <= rst_n ? {bsy[0], busy_pin} : 2'h0;
        ack <= rst_n ? {ack[0], ack_n_pin} : 2'h3;
    end
    always_ff @(posedge sys_clk) begin
        if (!rst_n || !req_valid || req_done || req_retry) begin
            wait_cnt <= 5'h00;
        end else begin
            wait_cnt <= wait_cnt + 5'h01;
        end
    end
    a_retry_budget: assert property (
        req_retry && !fifo |-> wait_cnt == 5'h0f) else $error("bad retry");
    a_no_rerun: assert property (
        req_done && !fifo |=> (!$fell(afd_n) && !$fell(slin_n)) [*2])
        else $error("cycle relaunched");
    a_data_release: assert property (
        !filter_en && !ecp_reverse && !afd_n && $rose(bsy[1])
        |-> ##[3:4] $rose(afd_n)) else $error("afd release time");
    a_addr_w_release: assert property (
        !filter_en && !slin_n && !pdata_oe_n && $rose(bsy[1])
        |-> ##[4:5] $rose(slin_n)) else $error("slin write release");
    a_addr_r_release: assert property (
        !filter_en && !slin_n && pdata_oe_n && $rose(bsy[1])
        |-> ##[3:4] $rose(slin_n)) else $error("slin read release");
    a_fifo_answer: assert property (
        req_valid && fifo |-> req_done || (req_write && req_retry))
        else $error("fifo access not answered");
    a_fwd_release: assert property (
        !filter_en && !stb_n && $rose(bsy[1]) |-> ##[2:3] $rose(stb_n))
        else $error("stb release time");
    a_rev_assert: assert property (
        ecp_reverse && !filter_en && $fell(ack[1]) |-> ##[3:4] $fell(afd_n))
        else $error("reverse afd late");
    a_rev_filtered: assert property (
        ecp_reverse && filter_en && $fell(ack[1]) |-> ##[5:6] $fell(afd_n))
        else $error("filtered afd time");
    a_rev_release: assert property (
        ecp_reverse && !filter_en && $rose(ack[1]) |-> ##[2:3] $rose(afd_n))
        else $error("reverse afd release");
    c_retry: cover property (req_retry && !fifo);
    c_collect: cover property (req_done && !fifo);
    c_reverse: cover property (ecp_reverse && $fell(afd_n));
endmodule // eecs_checker

bind eecs_sequencer eecs_checker u_chk (.sys_clk, .rst_n, .req_valid,
    .req_target, .req_write, .req_done, .req_retry, .filter_en, .ecp_reverse,
    .busy_pin, .ack_n_pin, .pdata_oe_n, .stb_n, .afd_n, .slin_n);

// [tb/eecs_peripheral.sv]
// peripheral model answering epp and ecp handshakes
// assumes strobes idle high and change just after clock edges
`timescale 1ns/1ps
module eecs_peripheral (
    // bench controls
    input wire logic sys_clk, input wire logic fwd_mode,
    input wire logic rev_go, input wire logic [3:0] lag,
    input wire logic [7:0] rbyte,
    // port pins
    input wire logic stb_n, input wire logic afd_n, input wire logic slin_n,
    output logic busy_pin, output logic ack_n_pin, output logic [7:0] pdata_in
);
    logic [3:0] cnt = 4'h0;
    logic [3:0] dv = 4'h0;
    logic want;
    // busy follows the active strobe after lag clocks
    assign want = fwd_mode ? !stb_n : (!afd_n || !slin_n);
    // byte valid near a handshake, inverted elsewhere
    assign pdata_in = (busy_pin || !ack_n_pin || |dv) ? rbyte : ~rbyte;
    initial begin
        busy_pin = 1'b0;
        ack_n_pin = 1'b1;
    end
    always @(posedge sys_clk) begin
        dv <= {dv[2:0], busy_pin || !ack_n_pin};
        cnt <= (want != busy_pin) ? cnt + 4'h1 : 4'h0;
        if (want != busy_pin && cnt >= lag) begin
            busy_pin <= want;
        end
        if (!afd_n) begin
            ack_n_pin <= 1'b1;
        end else if (rev_go) begin
            ack_n_pin <= 1'b0;
        end
    end
endmodule // eecs_peripheral

// [tb/test_epp_ecp_cycle_sequencer.sv]
// self-checking bench for the epp/ecp cycle sequencer
// assumes the peripheral model and the bound checker beside the design
`timescale 1ns/1ps
module test_epp_ecp_cycle_sequencer;
    logic sys_clk = 1'b0, rst_n = 1'b0, req_valid = 1'b0, req_write = 1'b0;
    logic [1:0] req_target = 2'h0;
    logic [7:0] req_wdata = 8'h00, rbyte = 8'h3c, req_rdata, pdata_in;
    logic [7:0] pdata_out;
    logic filter_en = 1'b0, ecp_reverse = 1'b0, fwd_mode = 1'b0, rev_go = 1'b0;
    logic [3:0] lag = 4'h8;
    logic req_done, req_retry, busy_pin, ack_n_pin, pdata_oe_n, stb_n, afd_n;
    logic slin_n, p_afd = 1'b1, p_slin = 1'b1, p_stb = 1'b1, got_d, got_r;
    logic [7:0] sent[$], got_data;
    int miscompares = 0, tests_run = 0, afd_falls, slin_falls, got_cyc, k;
    eecs_sequencer #(.FIFO_DEPTH(16)) u_dut (.sys_clk, .rst_n, .req_valid,
        .req_write, .req_target, .req_wdata, .req_done, .req_retry, .req_rdata,
        .filter_en, .ecp_reverse, .busy_pin, .ack_n_pin, .pdata_in, .pdata_out,
        .pdata_oe_n, .stb_n, .afd_n, .slin_n);
    eecs_peripheral u_per (.sys_clk, .fwd_mode, .rev_go, .lag, .rbyte, .stb_n,
        .afd_n, .slin_n, .busy_pin, .ack_n_pin, .pdata_in);
    always #10 sys_clk = ~sys_clk;
    always @(negedge sys_clk) begin
        if (p_afd && !afd_n) afd_falls++;
        if (p_slin && !slin_n) slin_falls++;
        if (p_stb && !stb_n) sent.push_back(pdata_out);
        p_afd = afd_n;
        p_slin = slin_n;
        p_stb = stb_n;
    end
    task automatic chk(input string nm, input logic [7:0] got, exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic guard(input int lim);
        if (k >= lim) begin
            miscompares++;
            end_of_test();
        end
    endtask
    // one request, held until answered
    task automatic access(input logic wr, input logic [1:0] tg,
        input logic [7:0] wd);
        @(posedge sys_clk);
        req_valid <= 1'b1;
        req_write <= wr;
        req_target <= tg;
        req_wdata <= wd;
        got_d = 1'b0;
        got_r = 1'b0;
        for (k = 1; k < 40 && !(got_d || got_r); k++) begin
            @(negedge sys_clk);
            got_d = req_done === 1'b1;
            got_r = req_retry === 1'b1;
            got_cyc = k;
        end
        guard(40);
        @(posedge sys_clk);
        req_valid <= 1'b0;
        @(negedge sys_clk);
        got_data = req_rdata;
    endtask
    task automatic t_epp(input logic wr, input logic [1:0] tg,
        input int na, ns);
        afd_falls = 0;
        slin_falls = 0;
        sent.delete();
        access(wr, tg, 8'ha5);
        chk("retry clock", got_r ? 8'(got_cyc) : 8'h00, 8'h10);
        for (int i = 0; i < 6 && !got_d; i++) access(wr, tg, 8'ha5);
        chk("retry collected", {7'h00, got_d}, 8'h01);
        chk("data strobes", 8'(afd_falls), 8'(na));
        chk("address strobes", 8'(slin_falls), 8'(ns));
        chk("data drive", {7'h00, pdata_oe_n}, {7'h00, !wr});
        if (wr && na == 1) chk("write byte", sent[0], 8'ha5);
        if (!wr) chk("read byte", got_data, 8'h3c);
        repeat (8) @(negedge sys_clk);
        $display("epp test done");
    endtask
    task automatic t_fwd();
        @(posedge sys_clk);
        fwd_mode <= 1'b1;
        lag <= 4'h2;
        sent.delete();
        access(1'b1, eecs_pkg::TGT_ECP_FIFO, 8'h11);
        chk("first write done", {7'h00, got_d}, 8'h01);
        access(1'b1, eecs_pkg::TGT_ECP_FIFO, 8'h22);
        chk("second write done", {7'h00, got_d}, 8'h01);
        for (k = 0; k < 99 && !(sent.size() == 2 && stb_n); k++)
            @(negedge sys_clk);
        guard(99);
        chk("first byte", sent[0], 8'h11);
        chk("second byte", sent[1], 8'h22);
        repeat (8) @(negedge sys_clk);
        fwd_mode <= 1'b0;
        $display("forward test done");
    endtask
    task automatic t_rev(input logic filt);
        @(posedge sys_clk);
        ecp_reverse <= 1'b1;
        filter_en <= filt;
        rbyte <= 8'h5a + filt;
        rev_go <= 1'b1;
        for (k = 0; k < 50 && afd_n !== 1'b0; k++) @(negedge sys_clk);
        guard(50);
        @(posedge sys_clk);
        rev_go <= 1'b0;
        for (k = 0; k < 50 && afd_n !== 1'b1; k++) @(negedge sys_clk);
        guard(50);
        afd_falls = 0;
        access(1'b0, eecs_pkg::TGT_ECP_FIFO, 8'h00);
        chk("fifo read done", {7'h00, got_d}, 8'h01);
        chk("reverse byte", got_data, 8'h5a + filt);
        repeat (8) @(negedge sys_clk);
        chk("no reverse start", 8'(afd_falls), 8'h00);
        $display("reverse test done");
    endtask
    initial begin
        repeat (16) @(posedge sys_clk);
        rst_n <= 1'b1;
        t_epp(1'b1, eecs_pkg::TGT_EPP_DATA, 1, 0);
        t_epp(1'b0, eecs_pkg::TGT_EPP_DATA, 1, 0);
        t_epp(1'b1, eecs_pkg::TGT_EPP_ADDR, 0, 2);
        t_epp(1'b0, eecs_pkg::TGT_EPP_ADDR, 0, 1);
        t_fwd();
        t_rev(1'b0);
        t_rev(1'b1);
        end_of_test();
    end
endmodule // test_epp_ecp_cycle_sequencer
